/* src/ank_pkg.sv */
// package for the auto-negotiation ability register pair
// assumes a 16-bit management register port and a 5-bit register address
package ank_pkg;

	// register addresses on the management port
	localparam logic [4:0] ANK_ADDR_LOCAL = 5'h04;
	localparam logic [4:0] ANK_ADDR_PARTNER = 5'h05;
	localparam int ANK_ADDR_W = 5;
	localparam int ANK_DATA_W = 16;

	// field positions, shared by both registers
	localparam int ANK_B_NEXT_PAGE = 15;
	localparam int ANK_B_ACK = 14;
	localparam int ANK_B_RFAULT = 13;
	localparam int ANK_B_RSV_HI = 12;
	localparam int ANK_B_RSV_LO = 11;
	localparam int ANK_B_PAUSE = 10;
	localparam int ANK_B_T4 = 9;
	localparam int ANK_B_FAST_FD = 8;
	localparam int ANK_B_FAST_HD = 7;
	localparam int ANK_B_TEN_FD = 6;
	localparam int ANK_B_TEN_HD = 5;
	localparam int ANK_B_SEL_HI = 4;
	localparam int ANK_B_SEL_LO = 0;

	// values after reset
	localparam logic ANK_RST_LOCAL_ACK = 1'b0;
	localparam logic ANK_RST_LOCAL_RF = 1'b0;
	localparam logic [1:0] ANK_RST_LOCAL_RSV = 2'h0;
	localparam logic ANK_RST_LOCAL_PAUSE = 1'b0;
	localparam logic ANK_RST_LOCAL_MODE = 1'b1;
	localparam logic [4:0] ANK_RST_LOCAL_SEL = 5'h01;
	localparam logic ANK_RST_PARTNER_BIT = 1'b0;
	localparam logic [4:0] ANK_RST_PARTNER_SEL = 5'h00;
	localparam logic [15:0] ANK_RST_WORD = 16'h0000;

endpackage : ank_pkg

/* src/ank_local_adv.sv */
// local advertisement register storage and outgoing base page word
// assumes write strobe is already decoded; ack level comes from arbitration
`timescale 1ns/1ps
module ank_local_adv
	import ank_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [15:0] wdata,
	input wire logic ack_in,
	output logic [15:0] adv_word
);

	typedef struct packed {
		logic ack;
		logic rfault;
		logic [1:0] rsv;
		logic pause;
		logic fast_fd;
		logic fast_hd;
		logic ten_fd;
		logic ten_hd;
		logic [4:0] sel;
	} ank_adv_t;

	ank_adv_t st_r;
	ank_adv_t st_nxt;

	// ack follows arbitration only; a management write never touches it
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = ack_in; // RULE3
		if (wr_en) begin
			st_nxt.rfault = wdata[ANK_B_RFAULT]; // RULE5
			st_nxt.rsv = wdata[ANK_B_RSV_HI:ANK_B_RSV_LO];
			st_nxt.pause = wdata[ANK_B_PAUSE]; // RULE6
			st_nxt.fast_fd = wdata[ANK_B_FAST_FD]; // RULE8
			st_nxt.fast_hd = wdata[ANK_B_FAST_HD]; // RULE8
			st_nxt.ten_fd = wdata[ANK_B_TEN_FD]; // RULE8
			st_nxt.ten_hd = wdata[ANK_B_TEN_HD]; // RULE8
			st_nxt.sel = wdata[ANK_B_SEL_HI:ANK_B_SEL_LO]; // RULE9
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.ack <= ANK_RST_LOCAL_ACK;
			st_r.rfault <= ANK_RST_LOCAL_RF;
			st_r.rsv <= ANK_RST_LOCAL_RSV;
			st_r.pause <= ANK_RST_LOCAL_PAUSE;
			st_r.fast_fd <= ANK_RST_LOCAL_MODE;
			st_r.fast_hd <= ANK_RST_LOCAL_MODE;
			st_r.ten_fd <= ANK_RST_LOCAL_MODE;
			st_r.ten_hd <= ANK_RST_LOCAL_MODE;
			st_r.sel <= ANK_RST_LOCAL_SEL;
		end else begin
			st_r <= st_nxt;
		end
	end

	// no next page and no four-pair mode: those bits are tied low
	assign adv_word = {1'b0, st_r.ack, st_r.rfault, st_r.rsv, // RULE2
		st_r.pause, 1'b0, st_r.fast_fd, st_r.fast_hd, // RULE7
		st_r.ten_fd, st_r.ten_hd, st_r.sel};

endmodule : ank_local_adv

/* src/ank_partner_cap.sv */
// link partner ability capture from received base pages
// assumes rx_valid is a one-cycle pulse per accepted page
`timescale 1ns/1ps
module ank_partner_cap
	import ank_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic rx_valid,
	input wire logic [15:0] rx_word,
	input wire logic wr_en,
	input wire logic [15:0] wdata,
	output logic [15:0] lp_word,
	output logic rf_rise
);

	typedef struct packed {
		logic np;
		logic ack;
		logic rfault;
		logic pause;
		logic t4;
		logic fast_fd;
		logic fast_hd;
		logic ten_fd;
		logic ten_hd;
		logic [4:0] sel;
		logic rf_rise;
	} ank_lp_t;

	ank_lp_t st_r;
	ank_lp_t st_nxt;

	// a received page wins over a write to the pause bit in the same cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.rf_rise = 1'b0;
		if (rx_valid) begin
			st_nxt.np = rx_word[ANK_B_NEXT_PAGE]; // RULE11
			st_nxt.ack = rx_word[ANK_B_ACK]; // RULE12
			st_nxt.rfault = rx_word[ANK_B_RFAULT]; // RULE13
			st_nxt.pause = rx_word[ANK_B_PAUSE]; // RULE14
			st_nxt.t4 = rx_word[ANK_B_T4]; // RULE15
			st_nxt.fast_fd = rx_word[ANK_B_FAST_FD]; // RULE15
			st_nxt.fast_hd = rx_word[ANK_B_FAST_HD]; // RULE15
			st_nxt.ten_fd = rx_word[ANK_B_TEN_FD]; // RULE15
			st_nxt.ten_hd = rx_word[ANK_B_TEN_HD]; // RULE15
			st_nxt.sel = rx_word[ANK_B_SEL_HI:ANK_B_SEL_LO]; // RULE16
			st_nxt.rf_rise = rx_word[ANK_B_RFAULT] & ~st_r.rfault; // RULE17
		end else if (wr_en) begin
			st_nxt.pause = wdata[ANK_B_PAUSE]; // RULE14
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.np <= ANK_RST_PARTNER_BIT;
			st_r.ack <= ANK_RST_PARTNER_BIT;
			st_r.rfault <= ANK_RST_PARTNER_BIT;
			st_r.pause <= ANK_RST_PARTNER_BIT;
			st_r.t4 <= ANK_RST_PARTNER_BIT;
			st_r.fast_fd <= ANK_RST_PARTNER_BIT;
			st_r.fast_hd <= ANK_RST_PARTNER_BIT;
			st_r.ten_fd <= ANK_RST_PARTNER_BIT;
			st_r.ten_hd <= ANK_RST_PARTNER_BIT;
			st_r.sel <= ANK_RST_PARTNER_SEL;
			st_r.rf_rise <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// reserved bits 12:11 read as zero
	assign lp_word = {st_r.np, st_r.ack, st_r.rfault, 2'b00, st_r.pause,
		st_r.t4, st_r.fast_fd, st_r.fast_hd, st_r.ten_fd, st_r.ten_hd,
		st_r.sel};
	assign rf_rise = st_r.rf_rise;

endmodule : ank_partner_cap

/* src/ank_ability_regs.sv */
// auto-negotiation ability registers: local advertisement and partner
// capture, on the management register port
// assumes the arbitration logic supplies ack level, page strobe and run level
`timescale 1ns/1ps

// Summary of operation
// RULE1 - local advertisement word is sent to the partner during negotiation
// RULE2 - local next page bit always reads zero
// RULE3 - local ack bit driven by negotiation logic, resets to zero
// RULE4 - software must not write either ack bit
// RULE5 - local remote fault bit writable, resets zero, advertises local fault
// RULE6 - local pause bit writable, resets zero, advertises flow control
// RULE7 - local four-pair ability bit read-only zero
// RULE8 - local four speed and duplex bits writable, reset to one
// RULE9 - local selector writable, resets to 00001
// RULE10 - partner register loaded from received page, otherwise read-only; the code also takes management writes to the pause bit
// RULE11 - partner next page bit from received page, resets zero
// RULE12 - partner ack bit updated from incoming bursts
// RULE13 - partner remote fault bit from received page, resets zero
// RULE14 - partner pause bit reports partner flow control, writable, resets zero
// RULE15 - partner ability bits copy received page, reset zero
// RULE16 - partner selector copies received code, resets 00000
// RULE17 - partner remote fault rising raises latched status fault flag
module ank_ability_regs
	import ank_pkg::*;
#(
	parameter int ADDR_W = ANK_ADDR_W,
	parameter int DATA_W = ANK_DATA_W
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [DATA_W-1:0] mgmt_wdata,
	output logic [DATA_W-1:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic an_running,
	input wire logic an_local_ack,
	input wire logic an_rx_valid,
	input wire logic [DATA_W-1:0] an_rx_page,
	output logic [DATA_W-1:0] an_tx_page,
	output logic an_tx_valid,
	output logic status_rf_set
);

	// the field map is fixed at 16 bits and a 5-bit management address,
	// so any other width is refused when the design is elaborated
	if (ADDR_W != ANK_ADDR_W || DATA_W != ANK_DATA_W) begin : g_bad_width
		$error("ank_ability_regs: unsupported width");
	end

	typedef struct packed {
		logic [15:0] rdata;
		logic rvalid;
		logic [15:0] tx_page;
		logic tx_valid;
		logic rf_set;
	} ank_top_t;

	ank_top_t st_r;
	ank_top_t st_nxt;
	logic wr_local;
	logic wr_partner;
	logic [15:0] adv_word;
	logic [15:0] lp_word;
	logic lp_rf_rise;

	// address match, used for both reads and writes
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [4:0] ref_addr);
		hit = (a == ref_addr);
	endfunction : hit

	// write strobes; ack bits are simply not stored from writes
	assign wr_local = mgmt_wr & hit(mgmt_addr, ANK_ADDR_LOCAL); // RULE4
	assign wr_partner = mgmt_wr & hit(mgmt_addr, ANK_ADDR_PARTNER); // RULE10

	ank_local_adv u_local (
		.core_clk(core_clk),
		.resetn(resetn),
		.wr_en(wr_local),
		.wdata(mgmt_wdata),
		.ack_in(an_local_ack),
		.adv_word(adv_word)
	);

	ank_partner_cap u_partner (
		.core_clk(core_clk),
		.resetn(resetn),
		.rx_valid(an_rx_valid),
		.rx_word(an_rx_page),
		.wr_en(wr_partner),
		.wdata(mgmt_wdata),
		.lp_word(lp_word),
		.rf_rise(lp_rf_rise)
	);

	// read mux, outgoing page and fault forward, all registered
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		if (mgmt_rd) begin
			st_nxt.rvalid = 1'b1;
			if (hit(mgmt_addr, ANK_ADDR_LOCAL))
				st_nxt.rdata = adv_word;
			else if (hit(mgmt_addr, ANK_ADDR_PARTNER))
				st_nxt.rdata = lp_word;
			else
				st_nxt.rdata = ANK_RST_WORD; // unmapped reads as zero
		end
		// page is frozen while idle so the partner never sees half a write
		if (an_running)
			st_nxt.tx_page = adv_word; // RULE1
		st_nxt.tx_valid = an_running; // RULE1
		st_nxt.rf_set = lp_rf_rise; // RULE17
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.rdata <= ANK_RST_WORD;
			st_r.rvalid <= 1'b0;
			st_r.tx_page <= ANK_RST_WORD;
			st_r.tx_valid <= 1'b0;
			st_r.rf_set <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mgmt_rdata = st_r.rdata;
	assign mgmt_rvalid = st_r.rvalid;
	assign an_tx_page = st_r.tx_page;
	assign an_tx_valid = st_r.tx_valid;
	assign status_rf_set = st_r.rf_set;

endmodule : ank_ability_regs

/* dv/ank_ability_regs_asserts.sv */
// checker for the ability register pair, watching only the top ports
// assumes one clock domain and the registered answers of the hand-over
`timescale 1ns/1ps
module ank_ability_regs_chk
	import ank_pkg::*;
#(
	parameter int ADDR_W = ANK_ADDR_W,
	parameter int DATA_W = ANK_DATA_W
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [DATA_W-1:0] mgmt_wdata,
	input wire logic [DATA_W-1:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic an_running,
	input wire logic an_local_ack,
	input wire logic an_rx_valid,
	input wire logic [DATA_W-1:0] an_rx_page,
	input wire logic [DATA_W-1:0] an_tx_page,
	input wire logic an_tx_valid,
	input wire logic status_rf_set
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// read handshake: exactly one answer cycle per read
	a_rd_answer: assert property (mgmt_rd |=> mgmt_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_cause: assert property (mgmt_rvalid |-> $past(mgmt_rd))
		else $error("answer without read");
	a_local_fixed: assert property (mgmt_rvalid &&
		$past(mgmt_addr) == ANK_ADDR_LOCAL |->
		!mgmt_rdata[15] && !mgmt_rdata[9]) else $error("fixed bit set");
	a_unmapped_zero: assert property (mgmt_rvalid &&
		$past(mgmt_addr) != ANK_ADDR_LOCAL &&
		$past(mgmt_addr) != ANK_ADDR_PARTNER |-> mgmt_rdata == '0)
		else $error("unmapped read not zero");
	// outgoing page follows the run level and freezes outside it
	a_tx_valid: assert property ($past(resetn) |->
		an_tx_valid == $past(an_running)) else $error("tx valid wrong");
	a_tx_frozen: assert property ($past(resetn) && !$past(an_running)
		|-> $stable(an_tx_page)) else $error("tx page moved");
	a_tx_ack: assert property ($past(resetn, 2) && $past(resetn) &&
		$past(an_running) |-> an_tx_page[14] == $past(an_local_ack, 2))
		else $error("tx ack lag wrong");
	// fault pulse: single cycle, two edges after a faulting page
	a_rf_pulse: assert property (status_rf_set |=> !status_rf_set)
		else $error("fault pulse too long");
	a_rf_cause: assert property (status_rf_set |->
		$past(an_rx_valid, 2) && ($past(an_rx_page, 2) & 16'h2000) != 0)
		else $error("fault pulse without page");
	// partner capture seen by a read; writable and reserved bits masked
	a_lp_load: assert property (mgmt_rvalid && $past(mgmt_rd) &&
		$past(mgmt_addr) == ANK_ADDR_PARTNER && $past(an_rx_valid, 3) &&
		!$past(an_rx_valid, 2) && !$past(an_rx_valid) |->
		(mgmt_rdata & 16'hE3FF) == ($past(an_rx_page, 3) & 16'hE3FF))
		else $error("partner capture wrong");
endmodule : ank_ability_regs_chk

bind ank_ability_regs ank_ability_regs_chk #(
	.ADDR_W(ADDR_W),
	.DATA_W(DATA_W)
) chk_u (.core_clk, .resetn, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
	.mgmt_rdata, .mgmt_rvalid, .an_running, .an_local_ack, .an_rx_valid,
	.an_rx_page, .an_tx_page, .an_tx_valid, .status_rf_set);

/* dv/ank_link_partner.sv */
// link partner model: hands received base pages to the ability block
// assumes a page is taken on the edge that sees an_rx_valid high
`timescale 1ns/1ps
module ank_link_partner (
	input wire logic core_clk,
	output logic an_rx_valid,
	output logic [15:0] an_rx_page
);
	initial begin
		an_rx_valid = 1'b0;
		an_rx_page = 16'h5A5A;
	end

	// one page per call; the inverse follows so a stale page never looks fresh
	task automatic send(input logic [15:0] p);
		@(posedge core_clk);
		an_rx_valid <= 1'b1;
		an_rx_page <= p;
		@(posedge core_clk);
		an_rx_valid <= 1'b0;
		an_rx_page <= ~p;
		#1;
	endtask : send
endmodule : ank_link_partner

/* dv/ank_ability_regs_tb_top.sv */
// testbench for the ability registers with a link partner model
// assumes the management strobes and answer timing of the hand-over
`timescale 1ns/1ps
module ank_ability_regs_tb_top
	import ank_pkg::*;
;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] mgmt_addr = 5'h00;
	logic mgmt_wr = 1'b0;
	logic mgmt_rd = 1'b0;
	logic an_running = 1'b0;
	logic an_local_ack = 1'b0;
	logic [15:0] mgmt_wdata = 16'h0000;
	logic [15:0] mgmt_rdata, an_rx_page, an_tx_page;
	logic mgmt_rvalid, an_rx_valid, an_tx_valid, status_rf_set;
	int error_cnt = 0;
	int total_checks = 0;
	int rf_cnt = 0;

	always #50 core_clk = ~core_clk;

	ank_ability_regs dut_u (.core_clk, .resetn, .mgmt_addr, .mgmt_wr,
		.mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .an_running,
		.an_local_ack, .an_rx_valid, .an_rx_page, .an_tx_page,
		.an_tx_valid, .status_rf_set);
	ank_link_partner lp_u (.core_clk, .an_rx_valid, .an_rx_page);

	// count fault pulses; timing itself is left to the checker
	always @(posedge core_clk) if (status_rf_set === 1'b1) rf_cnt++;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		mgmt_wr <= 1'b1;
		mgmt_addr <= a;
		mgmt_wdata <= d;
		@(posedge core_clk);
		mgmt_wr <= 1'b0;
		#1;
	endtask : wr

	// answer is checked just after the edge that launches it
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		mgmt_rd <= 1'b1;
		mgmt_addr <= a;
		@(posedge core_clk);
		mgmt_rd <= 1'b0;
		#1;
		chk({15'h0000, mgmt_rvalid}, 16'h0001);
		chk(mgmt_rdata, exp);
	endtask : rd

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// walk both registers, the outgoing page and the fault pulse
	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd(5'h04, 16'h01E1);
		rd(5'h05, 16'h0000);
		wr(5'h04, 16'hFFFF);
		rd(5'h04, 16'h3DFF);
		wr(5'h04, 16'h0000);
		rd(5'h04, 16'h0000);
		wr(5'h04, 16'h2421);
		@(posedge core_clk);
		an_running <= 1'b1;
		an_local_ack <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk(an_tx_page, 16'h6421);
		chk({15'h0000, an_tx_valid}, 16'h0001);
		@(posedge core_clk);
		an_running <= 1'b0;
		wr(5'h04, 16'h01E1);
		repeat (3) @(posedge core_clk);
		#1;
		chk(an_tx_page, 16'h6421);
		chk({15'h0000, an_tx_valid}, 16'h0000);
		wr(5'h06, 16'h1234);
		rd(5'h06, 16'h0000);
		rd(5'h04, 16'h41E1);
		lp_u.send(16'hFFFF);
		rd(5'h05, 16'hE7FF);
		wr(5'h05, 16'h0000);
		rd(5'h05, 16'hE3FF);
		lp_u.send(16'h4001);
		rd(5'h05, 16'h4001);
		wr(5'h05, 16'hFFFF);
		rd(5'h05, 16'h4401);
		lp_u.send(16'h2000);
		lp_u.send(16'h2000);
		rd(5'h05, 16'h2000);
		chk(16'(rf_cnt), 16'h0002);
		@(posedge core_clk);
		resetn <= 1'b0;
		an_local_ack <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(5'h04, 16'h01E1);
		rd(5'h05, 16'h0000);
		final_report();
	end

	// hang guard, well beyond the fewer than 80 cycles the tests take
	initial begin
		repeat (3000) @(posedge core_clk);
		error_cnt++;
		final_report();
	end
endmodule : ank_ability_regs_tb_top
